// >>> inc/refsel_regs.svh
`ifndef REFSEL_REGS_SVH
`define REFSEL_REGS_SVH

// Register offsets
`define REFSEL_RANK_ADDR 8'h14
`define REFSEL_MODE_ADDR 8'h15
`define REFSEL_HOLD_ADDR 8'h16
`define REFSEL_MON_ADDR 8'h17

// Field positions, selection mode register
`define REFSEL_LOSS_BLOCK_BIT 6
`define REFSEL_PRESCALE_BIT 5
`define REFSEL_REVERT_BIT 4
`define REFSEL_MODE_MSB 3
`define REFSEL_MODE_LSB 2
`define REFSEL_CHOICE_MSB 1
`define REFSEL_CHOICE_LSB 0

// Field positions, monitor and power-down register
`define REFSEL_RATE_MSB 7
`define REFSEL_RATE_LSB 6
`define REFSEL_PD_MSB 5
`define REFSEL_PD_LSB 2
`define REFSEL_MONDIV_MSB 1
`define REFSEL_MONDIV_LSB 0

// Reset values
`define REFSEL_RANK_RST 8'he4
`define REFSEL_MODE_RST 8'h00
`define REFSEL_HOLD_RST 8'h80
`define REFSEL_MON_RST 8'h00

`endif

// >>> inc/refsel_pkg.sv
package refsel_pkg;

   typedef enum logic [1:0] {
      MODE_MANUAL     = 2'b00,
      MODE_AUTO       = 2'b01,
      MODE_SHORT_HOLD = 2'b10,
      MODE_AUTO_HOLD  = 2'b11
   } ref_choice_mode_t;

   typedef enum logic [1:0] {
      ST_TRACK   = 2'b00,
      ST_HOLDOFF = 2'b01
   } sel_fsm_t;

   typedef struct packed {
      logic [3:0][1:0] input_rank;
      logic reference_loss_block;
      logic monitor_prescale;
      logic revertive_switch_enable;
      ref_choice_mode_t ref_choice_mode;
      logic [1:0] manual_choice;
      logic [7:0] holdoff_count_setting;
      logic [1:0] holdoff_rate_divider;
      logic [3:0] input_power_down;
      logic [1:0] activity_monitor_divide;
   } sel_cfg_t;

   typedef struct packed {
      sel_cfg_t cfg;
      sel_fsm_t fsm;
      logic [7:0] holdoff_cnt;
      logic [1:0] sel;
      logic [3:0] loss_meta;
      logic [3:0] loss_sync;
      logic [3:0] loss_prev;
      logic [7:0] rdata;
   } sel_state_t;

   typedef struct packed {
      logic [1:0] holdoff_rate_divider;
      logic [1:0] activity_monitor_divide;
      logic [3:0] input_power_down;
      logic monitor_prescale;
      logic reference_loss_block;
   } monitor_ctl_t;

endpackage

// >>> core/reference_input_selector.sv
`timescale 1ns/100ps
`include "refsel_regs.svh"
module reference_input_selector (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic reset_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   output logic [7:0] reg_rdata_o,
   // Input status
   input wire logic [3:0] input_signal_absent_i,
   input wire logic holdoff_tick_i,
   // Selection and monitor control
   output logic [1:0] ref_select_o,
   output logic holdoff_active_o,
   output refsel_pkg::monitor_ctl_t monitor_ctl_o
);

   refsel_pkg::sel_state_t q, n;

   function automatic refsel_pkg::sel_cfg_t cfg_write(input refsel_pkg::sel_cfg_t c, input logic [7:0] a,
                                                     input logic [7:0] w);
      refsel_pkg::sel_cfg_t r;
      r = c;
      unique case (a)
         `REFSEL_RANK_ADDR: r.input_rank = {w[1:0], w[3:2], w[5:4], w[7:6]};
         `REFSEL_MODE_ADDR: begin
            r.reference_loss_block = w[`REFSEL_LOSS_BLOCK_BIT];
            r.monitor_prescale = w[`REFSEL_PRESCALE_BIT];
            r.revertive_switch_enable = w[`REFSEL_REVERT_BIT];
            r.ref_choice_mode = refsel_pkg::ref_choice_mode_t'(w[`REFSEL_MODE_MSB:`REFSEL_MODE_LSB]);
            r.manual_choice = w[`REFSEL_CHOICE_MSB:`REFSEL_CHOICE_LSB];
         end
         `REFSEL_HOLD_ADDR: r.holdoff_count_setting = w;
         `REFSEL_MON_ADDR: begin
            r.holdoff_rate_divider = w[`REFSEL_RATE_MSB:`REFSEL_RATE_LSB];
            r.input_power_down = w[`REFSEL_PD_MSB:`REFSEL_PD_LSB];
            r.activity_monitor_divide = w[`REFSEL_MONDIV_MSB:`REFSEL_MONDIV_LSB];
         end
         default: r = c;
      endcase
      return r;
   endfunction

   function automatic logic [7:0] cfg_read(input refsel_pkg::sel_cfg_t c, input logic [7:0] a);
      logic [7:0] r;
      r = 8'h00;
      unique case (a)
         `REFSEL_RANK_ADDR: r = {c.input_rank[0], c.input_rank[1], c.input_rank[2], c.input_rank[3]};
         `REFSEL_MODE_ADDR: r = {1'b0, c.reference_loss_block, c.monitor_prescale, c.revertive_switch_enable,
                                 c.ref_choice_mode, c.manual_choice};
         `REFSEL_HOLD_ADDR: r = c.holdoff_count_setting;
         `REFSEL_MON_ADDR: r = {c.holdoff_rate_divider, c.input_power_down, c.activity_monitor_divide};
         default: r = 8'h00;
      endcase
      return r;
   endfunction

   // True when input a outranks input b
   function automatic logic outranks(input logic [3:0][1:0] rk, input logic [1:0] a, input logic [1:0] b);
      return (rk[a] > rk[b]) || ((rk[a] == rk[b]) && (a < b));
   endfunction

   // Best valid input; scanning down lets the lower index win ties
   function automatic logic [2:0] best_valid(input logic [3:0][1:0] rk, input logic [3:0] lost);
      logic found;
      logic [1:0] idx;
      found = 1'b0;
      idx = 2'b00;
      for (int i = 3; i >= 0; i--) begin
         if (!lost[i] && (!found || rk[i] >= rk[idx])) begin
            found = 1'b1;
            idx = 2'(i);
         end
      end
      return {found, idx};
   endfunction

   logic [2:0] best;
   logic auto_mode;
   logic cur_lost;
   logic [3:0] revalid;
   logic revert_hit;

   always_comb begin
      best = best_valid(q.cfg.input_rank, q.loss_sync);
      auto_mode = q.cfg.ref_choice_mode[0];
      cur_lost = q.loss_sync[q.sel];
      revalid = q.loss_prev & ~q.loss_sync;
      revert_hit = 1'b0;
      for (int j = 0; j < 4; j++) begin
         if (revalid[j] && (2'(j) != q.sel) && outranks(q.cfg.input_rank, 2'(j), q.sel)) begin
            revert_hit = 1'b1;
         end
      end

      n = q;
      n.loss_meta = input_signal_absent_i;
      n.loss_sync = q.loss_meta;
      n.loss_prev = q.loss_sync;
      n.rdata = cfg_read(q.cfg, reg_addr_i);
      if (reg_wr_i) begin
         n.cfg = cfg_write(q.cfg, reg_addr_i, reg_wdata_i);
      end

      if (!auto_mode) begin
         n.sel = q.cfg.manual_choice;
         n.fsm = refsel_pkg::ST_TRACK;
      end else begin
         unique case (q.fsm)
            refsel_pkg::ST_TRACK: begin
               if (cur_lost && best[2]) begin
                  if (q.cfg.ref_choice_mode == refsel_pkg::MODE_AUTO_HOLD &&
                      q.cfg.holdoff_count_setting != 8'h00) begin
                     n.fsm = refsel_pkg::ST_HOLDOFF;
                     n.holdoff_cnt = q.cfg.holdoff_count_setting;
                  end else begin
                     n.sel = best[1:0];
                  end
               end else if (!cur_lost && q.cfg.revertive_switch_enable && revert_hit) begin
                  n.sel = best[1:0];
               end
               // Otherwise the selection holds, revalidation included
            end
            refsel_pkg::ST_HOLDOFF: begin
               if (!cur_lost || q.cfg.ref_choice_mode != refsel_pkg::MODE_AUTO_HOLD) begin
                  n.fsm = refsel_pkg::ST_TRACK;
               end else if (holdoff_tick_i) begin
                  if (q.holdoff_cnt <= 8'h01) begin
                     // Zero transition: fail over, reload; keep waiting if nothing valid
                     n.holdoff_cnt = q.cfg.holdoff_count_setting;
                     if (best[2]) begin
                        n.sel = best[1:0];
                        n.fsm = refsel_pkg::ST_TRACK;
                     end
                  end else begin
                     n.holdoff_cnt = q.holdoff_cnt - 8'h01;
                  end
               end
            end
            default: n.fsm = refsel_pkg::ST_TRACK;
         endcase
      end

      if (reset_i) begin
         n = '0;
         n.cfg = cfg_write(cfg_write(cfg_write(cfg_write('0, `REFSEL_RANK_ADDR, `REFSEL_RANK_RST),
                 `REFSEL_MODE_ADDR, `REFSEL_MODE_RST), `REFSEL_HOLD_ADDR, `REFSEL_HOLD_RST),
                 `REFSEL_MON_ADDR, `REFSEL_MON_RST);
         n.holdoff_cnt = `REFSEL_HOLD_RST;
      end
   end

   always_ff @(posedge mclk_i) begin
      q <= n;
   end

   assign ref_select_o = q.sel;
   assign reg_rdata_o = q.rdata;
   assign holdoff_active_o = (q.fsm == refsel_pkg::ST_HOLDOFF);
   assign monitor_ctl_o = '{holdoff_rate_divider: q.cfg.holdoff_rate_divider,
                            activity_monitor_divide: q.cfg.activity_monitor_divide,
                            input_power_down: q.cfg.input_power_down,
                            monitor_prescale: q.cfg.monitor_prescale,
                            reference_loss_block: q.cfg.reference_loss_block};

   // Checks
   manual_route_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      !q.cfg.ref_choice_mode[0] |=> ref_select_o == $past(q.cfg.manual_choice))
      else $error("manual mode did not route the manual choice");

   // Previous cycle must be manual too, else the old automatic pick may still show
   manual_ignores_revert_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (!q.cfg.ref_choice_mode[0] && $stable(q.cfg.ref_choice_mode[0]) && q.cfg.revertive_switch_enable &&
       |revalid && $stable(q.cfg.manual_choice))
      |=> $stable(ref_select_o))
      else $error("revertive setting acted in manual mode");

   // Hold-off ended by a mode change keeps its input for one more cycle
   never_lost_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (q.cfg.ref_choice_mode == refsel_pkg::MODE_AUTO && q.fsm == refsel_pkg::ST_TRACK && !(&q.loss_sync))
      |=> !q.loss_prev[q.sel])
      else $error("automatic mode kept a lost input");

   failover_best_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (q.cfg.ref_choice_mode == refsel_pkg::MODE_AUTO && q.fsm == refsel_pkg::ST_TRACK && cur_lost && best[2])
      |=> ref_select_o == $past(best[1:0]))
      else $error("fail-over did not pick the best valid input");

   tie_break_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (q.cfg.ref_choice_mode == refsel_pkg::MODE_AUTO && q.fsm == refsel_pkg::ST_TRACK && cur_lost &&
       !q.loss_sync[0] &&
       q.cfg.input_rank == {4{q.cfg.input_rank[0]}}) |=> ref_select_o == 2'b00)
      else $error("equal ranks did not prefer input 0");

   no_revert_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (auto_mode && !q.cfg.revertive_switch_enable && !cur_lost && q.fsm == refsel_pkg::ST_TRACK)
      |=> $stable(ref_select_o))
      else $error("selection moved without cause");

   revert_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (auto_mode && q.cfg.revertive_switch_enable && !cur_lost && q.fsm == refsel_pkg::ST_TRACK && revert_hit)
      |=> ref_select_o == $past(best[1:0]) && ref_select_o != $past(ref_select_o))
      else $error("revertive switch missing");

   holdoff_wait_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (q.cfg.ref_choice_mode == refsel_pkg::MODE_AUTO_HOLD && q.fsm == refsel_pkg::ST_TRACK && cur_lost &&
       best[2] && q.cfg.holdoff_count_setting != 8'h00)
      |=> holdoff_active_o && $stable(ref_select_o) && q.holdoff_cnt == $past(q.cfg.holdoff_count_setting))
      else $error("hold-off did not start");

   reset_state_a: assert property (@(posedge mclk_i)
      reset_i |=> q.cfg.ref_choice_mode == refsel_pkg::MODE_MANUAL && !q.cfg.revertive_switch_enable &&
      !monitor_ctl_o.monitor_prescale && ref_select_o == 2'b00)
      else $error("reset values wrong");

   prescale_write_a: assert property (@(posedge mclk_i) disable iff (reset_i)
      (reg_wr_i && reg_addr_i == `REFSEL_MODE_ADDR)
      |=> monitor_ctl_o.monitor_prescale == $past(reg_wdata_i[`REFSEL_PRESCALE_BIT]))
      else $error("prescale bit not written");

   manual_cov_c: cover property (@(posedge mclk_i) disable iff (reset_i)
      !auto_mode ##1 ref_select_o == 2'b11);
   failover_cov_c: cover property (@(posedge mclk_i) disable iff (reset_i)
      auto_mode && cur_lost ##1 !cur_lost);
   holdoff_cov_c: cover property (@(posedge mclk_i) disable iff (reset_i)
      holdoff_active_o ##1 !holdoff_active_o && $changed(ref_select_o));
   revert_cov_c: cover property (@(posedge mclk_i) disable iff (reset_i)
      auto_mode && q.cfg.revertive_switch_enable && revert_hit);

endmodule

// >>> testbench/reference_input_selector_tb.sv
`timescale 1ns/100ps
`include "refsel_regs.svh"
module reference_input_selector_tb;
   logic mclk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [7:0] reg_addr_i = 8'h00;
   logic [7:0] reg_wdata_i = 8'h00;
   logic reg_wr_i = 1'b0;
   logic [7:0] reg_rdata_o;
   logic [3:0] input_signal_absent_i = 4'h0;
   logic holdoff_tick_i = 1'b0;
   logic [1:0] ref_select_o;
   logic holdoff_active_o;
   refsel_pkg::monitor_ctl_t monitor_ctl_o;
   int error_cnt = 0;
   int n_checks = 0;

   reference_input_selector reference_input_selector_i (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i),
      .reg_rdata_o(reg_rdata_o),
      .input_signal_absent_i(input_signal_absent_i),
      .holdoff_tick_i(holdoff_tick_i),
      .ref_select_o(ref_select_o),
      .holdoff_active_o(holdoff_active_o),
      .monitor_ctl_o(monitor_ctl_o)
   );

   initial begin
      forever #5 mclk_i = ~mclk_i;
   end

   task automatic wrap_up();
      if (error_cnt == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk_i);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      @(negedge mclk_i);
      reg_wr_i = 1'b0;
      @(negedge mclk_i);
   endtask

   // Read data trails the address by one edge, so look one cycle later
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge mclk_i);
      reg_addr_i = a;
      @(negedge mclk_i);
      chk("reg_rdata_o", {2'b00, exp}, {2'b00, reg_rdata_o});
   endtask

   // Two sync flops plus the decision edge, with margin
   task automatic loss(input logic [3:0] v);
      @(negedge mclk_i);
      input_signal_absent_i = v;
      repeat (5) @(negedge mclk_i);
   endtask

   task automatic tick();
      @(negedge mclk_i);
      holdoff_tick_i = 1'b1;
      @(negedge mclk_i);
      holdoff_tick_i = 1'b0;
      @(negedge mclk_i);
   endtask

   task automatic sel(input logic [1:0] exp);
      chk("ref_select_o", {8'h00, exp}, {8'h00, ref_select_o});
   endtask

   initial begin
      repeat (20000) @(posedge mclk_i);
      error_cnt++;
      wrap_up();
   end

   initial begin
      repeat (6) @(negedge mclk_i);
      reset_i = 1'b0;
      sel(2'h0);
      chk("holdoff_active_o", 10'h000, {9'h000, holdoff_active_o});
      chk("monitor_ctl_o", 10'h000, monitor_ctl_o);
      rd(`REFSEL_RANK_ADDR, 8'he4);
      rd(`REFSEL_MODE_ADDR, 8'h00);
      rd(`REFSEL_HOLD_ADDR, 8'h80);
      rd(`REFSEL_MON_ADDR, 8'h00);
      rd(8'h20, 8'h00);
      wr(8'h20, 8'h5a);
      rd(8'h20, 8'h00);
      // Top bit of the mode register is reserved and reads zero
      wr(`REFSEL_MODE_ADDR, 8'hff);
      rd(`REFSEL_MODE_ADDR, 8'h7f);
      wr(`REFSEL_MON_ADDR, 8'ha6);
      wr(`REFSEL_MODE_ADDR, 8'h60);
      rd(`REFSEL_MON_ADDR, 8'ha6);
      chk("monitor_ctl_o", {2'h2, 2'h2, 4'h9, 1'b1, 1'b1}, monitor_ctl_o);
      wr(`REFSEL_MODE_ADDR, 8'h20);
      chk("monitor_ctl_o", {2'h2, 2'h2, 4'h9, 1'b1, 1'b0}, monitor_ctl_o);
      wr(`REFSEL_MON_ADDR, 8'h00);
      // Manual modes with revertive set and losses toggling: choice holds
      for (int m = 0; m < 4; m += 2) begin
         for (int c = 0; c < 4; c++) begin
            wr(`REFSEL_MODE_ADDR, 8'h10 | 8'(m << 2) | 8'(c));
            loss(4'h1 << c);
            sel(2'(c));
            loss(4'h0);
            sel(2'(c));
         end
      end
      wr(`REFSEL_MODE_ADDR, 8'h00);
      wr(`REFSEL_MODE_ADDR, 8'h07);
      sel(2'h0);
      loss(4'h1);
      sel(2'h1);
      loss(4'h3);
      sel(2'h2);
      loss(4'h7);
      sel(2'h3);
      loss(4'hf);
      sel(2'h3);
      loss(4'h0);
      sel(2'h3);
      wr(`REFSEL_RANK_ADDR, 8'h55);
      wr(`REFSEL_MODE_ADDR, 8'h14);
      loss(4'h1);
      loss(4'h0);
      sel(2'h0);
      loss(4'h4);
      loss(4'h0);
      sel(2'h0);
      wr(`REFSEL_RANK_ADDR, 8'h1b);
      loss(4'h1);
      sel(2'h3);
      loss(4'h0);
      sel(2'h3);
      // Hold-off: three ticks from a setting of three, then reload
      wr(`REFSEL_MODE_ADDR, 8'h00);
      wr(`REFSEL_RANK_ADDR, 8'he4);
      wr(`REFSEL_HOLD_ADDR, 8'h03);
      wr(`REFSEL_MODE_ADDR, 8'h0c);
      sel(2'h0);
      loss(4'h1);
      chk("holdoff_active_o", 10'h001, {9'h000, holdoff_active_o});
      tick();
      tick();
      sel(2'h0);
      chk("holdoff_active_o", 10'h001, {9'h000, holdoff_active_o});
      tick();
      sel(2'h1);
      chk("holdoff_active_o", 10'h000, {9'h000, holdoff_active_o});
      loss(4'h3);
      tick();
      tick();
      sel(2'h1);
      tick();
      sel(2'h2);
      // Selected input recovers during hold-off: no switch
      loss(4'h7);
      chk("holdoff_active_o", 10'h001, {9'h000, holdoff_active_o});
      loss(4'h3);
      chk("holdoff_active_o", 10'h000, {9'h000, holdoff_active_o});
      sel(2'h2);
      // Zero setting in hold mode fails over at once
      wr(`REFSEL_HOLD_ADDR, 8'h00);
      loss(4'h7);
      sel(2'h3);
      chk("holdoff_active_o", 10'h000, {9'h000, holdoff_active_o});
      // Second reset in mid-run restores the defaults
      @(negedge mclk_i);
      reset_i = 1'b1;
      repeat (2) @(negedge mclk_i);
      reset_i = 1'b0;
      sel(2'h0);
      rd(`REFSEL_MODE_ADDR, 8'h00);
      rd(`REFSEL_HOLD_ADDR, 8'h80);
      wrap_up();
   end
endmodule
